// >>> bench/core_model.sv
// processor core model: instruction stream, vector acceptance, returns
`timescale 1ns/100ps
module core_model
   import irq_power_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire vector_req_t vectorReq,
   input wire logic coreHalt,
   input wire logic coreReset,
   input wire logic retReq, // one-cycle request to end the current service routine
   output logic instrDone,
   output logic instrIsReturn,
   output logic vectorAck
);
   logic retPend; // return waiting for the next finished instruction
   logic [7:0] got[$]; // vectors taken, in order
   // one finished instruction every second cycle while running
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instrDone <= 1'b0;
         instrIsReturn <= 1'b0;
         retPend <= 1'b0;
      end else begin
         instrDone <= !instrDone && !coreHalt && !coreReset;
         instrIsReturn <= retPend && !instrDone && !coreHalt && !coreReset;
         if (retReq) retPend <= 1'b1;
         else if (instrIsReturn) retPend <= 1'b0;
      end
   end
   // take each offered vector the cycle after it appears
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) vectorAck <= 1'b0;
      else begin
         vectorAck <= vectorReq.valid && !vectorAck;
         if (vectorReq.valid && !vectorAck) got.push_back(vectorReq.vector);
      end
   end
endmodule // core_model

// >>> bench/irq_power_reset_control_assertions.sv
// checker: port timing and value properties of the interrupt and power controller
`timescale 1ns/100ps
module irq_power_reset_control_assertions
   import irq_power_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic vectorAck,
   input wire vector_req_t vectorReq,
   input wire logic coreHalt,
   input wire logic clockStop,
   input wire logic coreReset,
   input wire logic strobeHigh,
   input wire logic [7:0] portReset,
   input wire logic [7:0] stackReset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // strobes stay high through the whole sim hold span (8 cycles)
   sequence holdHigh;
      strobeHigh [*8];
   endsequence
   vec_hold_a: assert property (vectorReq.valid && !vectorAck |=> vectorReq.valid && $stable(vectorReq.vector))
      else $error("vector offer dropped or changed before ack");
   vec_map_a: assert property (vectorReq.valid |-> vectorReq.vector == 8'h03 + {2'b00, vectorReq.source, 3'b000})
      else $error("vector address does not match source");
   stop_halt_a: assert property (clockStop |-> coreHalt)
      else $error("clock stopped while core runs");
   rst_strobe_a: assert property (coreReset |-> strobeHigh)
      else $error("strobes not high during reset");
   strobe_hold_a: assert property ($fell(coreReset) |-> holdHigh ##[0:2] !strobeHigh)
      else $error("strobe hold span wrong");
   reset_vals_a: assert property (portReset == PORT_RESET && stackReset == STACK_RESET)
      else $error("port or stack reset value wrong");
   down_stay_a: assert property (clockStop && !coreReset |=> clockStop || coreReset)
      else $error("power-down left without reset");
   wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
endmodule // irq_power_reset_control_assertions
bind irq_power_reset_control irq_power_reset_control_assertions chk_inst (.*);

// >>> bench/irq_power_reset_control_test.sv
// testbench: priority, masking, idle, power-down, reset and register bus
`timescale 1ns/100ps
module irq_power_reset_control_test import irq_power_pkg::*; ;
   logic clk = 0, rst_n = 0, resetPin = 0, ext_irq_zero_n = 1, ext_irq_one_n = 1, retReq = 0;
   periph_events_t ev = '0;
   logic instrDone, instrIsReturn, vectorAck, coreHalt, clockStop, coreReset, strobeHigh;
   vector_req_t vectorReq;
   logic [7:0] portReset, stackReset, awaddr = 0, araddr = 0, d;
   logic [31:0] wdata = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   int err_count = 0, n_compared = 0;
   always #10 clk = ~clk;
   irq_power_reset_control #(.STROBE_HOLD(8)) irq_power_reset_control_inst (.clk(clk), .rst_n(rst_n),
      .resetPin(resetPin), .ext_irq_zero_n(ext_irq_zero_n), .ext_irq_one_n(ext_irq_one_n), .events(ev),
      .instrDone(instrDone), .instrIsReturn(instrIsReturn), .vectorAck(vectorAck), .vectorReq(vectorReq),
      .coreHalt(coreHalt), .clockStop(clockStop), .coreReset(coreReset), .strobeHigh(strobeHigh),
      .portReset(portReset), .stackReset(stackReset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   core_model core_model_inst (.clk(clk), .rst_n(rst_n), .vectorReq(vectorReq), .coreHalt(coreHalt),
      .coreReset(coreReset), .retReq(retReq), .instrDone(instrDone), .instrIsReturn(instrIsReturn),
      .vectorAck(vectorAck));
   // bus write: handshakes seen at the falling edge, released at the rising edge; bready and rready stay high
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic ta, tw, tb;
      awaddr <= a; wdata <= {24'h000000, v}; awvalid <= 1; wvalid <= 1;
      do begin
         @(negedge clk); ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
         @(posedge clk); if (ta) awvalid <= 0; if (tw) wvalid <= 0;
      end while (!tb);
   endtask
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      araddr <= a; arvalid <= 1;
      do begin
         @(negedge clk); ta = arvalid && arready; tr = rvalid; d = rdata[7:0]; r = rresp;
         @(posedge clk); if (ta) arvalid <= 0;
      end while (!tr);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin err_count++; $display("BAD %s exp %h got %h", nm, e, g); end
   endtask
   task automatic cyc(input int n); repeat (n) @(posedge clk); endtask
   task automatic fire(input periph_events_t e); ev <= e; @(posedge clk); ev <= '0; endtask
   task automatic ret(); retReq <= 1; @(posedge clk); retReq <= 0; cyc(10); endtask
   task automatic waitVec(input int n);
      for (int i = 0; i < 200 && core_model_inst.got.size() < n; i++) @(posedge clk);
   endtask
   function automatic logic [7:0] g(input int i); return core_model_inst.got[i]; endfunction
   task automatic tRegs();
      rd(ADDR_POWER); chk("power", 8'h00, d);
      rd(ADDR_LEVEL); chk("level", 8'h80, d);
      rd(ADDR_ENABLE); chk("enable", 8'h00, d);
      rd(8'h40); chk("rd bad", RESP_SLVERR, r);
      wr(8'h44, 8'h55); chk("wr bad", RESP_SLVERR, r);
      chk("port", 8'hFF, portReset); chk("stack", 8'h07, stackReset);
   endtask
   task automatic tPrio(input logic [7:0] lvl, input logic [7:0] v0, input logic [7:0] v1);
      wr(ADDR_LEVEL, lvl); wr(ADDR_ENABLE, 8'hA8); core_model_inst.got.delete();
      fire(5'b01100); waitVec(1); cyc(20);
      chk("first", v0, g(0));
      chk("nested", 1, core_model_inst.got.size());
      rd(ADDR_STATUS); chk("active", (lvl == 8'h00) ? 32'h10 : 32'h20, d);
      rd(ADDR_TIMER_CTL); chk("t1 flag", v0 != VEC_T1, d[T1_FLAG_BIT]);
      ret(); waitVec(2); chk("second", v1, g(1)); ret();
   endtask
   task automatic tMask();
      wr(ADDR_LEVEL, 8'h00); wr(ADDR_ENABLE, 8'h28); core_model_inst.got.delete();
      fire(5'b01000); cyc(20); chk("masked", 0, core_model_inst.got.size());
      wr(ADDR_ENABLE, 8'hA8); waitVec(1); chk("unmasked", VEC_T1, g(0)); ret();
   endtask
   task automatic tIdle();
      wr(ADDR_POWER, 8'h01); for (int i = 0; i < 50 && !coreHalt; i++) cyc(1);
      chk("idle halt", 2'b10, {coreHalt, clockStop});
      core_model_inst.got.delete(); fire(5'b01000); waitVec(1); cyc(4);
      chk("idle wake", 1'b0, coreHalt); chk("idle vec", VEC_T1, g(0));
      rd(ADDR_POWER); chk("idle bit", 1'b0, d[IDLE_BIT]); ret();
   endtask
   task automatic tExt();
      wr(ADDR_TIMER_CTL, 8'h01); wr(ADDR_ENABLE, 8'h85); core_model_inst.got.delete();
      ext_irq_zero_n <= 0; ext_irq_one_n <= 0; cyc(3); ext_irq_zero_n <= 1; waitVec(1); cyc(20);
      chk("edge vec", VEC_EXT0, g(0)); chk("edge once", 1, core_model_inst.got.size()); ret();
      waitVec(2); chk("level vec", VEC_EXT1, g(1)); ext_irq_one_n <= 1; ret();
   endtask
   task automatic tPower();
      wr(ADDR_ENABLE, 8'hA8); wr(ADDR_POWER, 8'h02);
      for (int i = 0; i < 50 && !clockStop; i++) cyc(1);
      core_model_inst.got.delete(); fire(5'b01000); cyc(20);
      chk("down stay", 2'b10, {clockStop, core_model_inst.got.size() != 0});
      resetPin <= 1; cyc(2); resetPin <= 0; cyc(10); chk("short rst", 1'b1, clockStop);
      resetPin <= 1; cyc(6); resetPin <= 0; cyc(4);
      for (int i = 0; i < 100 && strobeHigh; i++) cyc(1);
      chk("down exit", 1'b0, clockStop); rd(ADDR_ENABLE); chk("enable rst", 8'h00, d);
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      cyc(20); rst_n <= 1;
      for (int i = 0; i < 100 && strobeHigh; i++) cyc(1);
      tRegs();
      tPrio(8'h00, VEC_T1, VEC_T2);
      tPrio(8'h20, VEC_T2, VEC_T1);
      tMask(); tIdle(); tExt(); tPower();
      conclude();
   end
   // watchdog: far beyond the few hundred cycles the run needs
   initial begin
      cyc(20000); err_count++; conclude();
   end
endmodule // irq_power_reset_control_test

// >>> hdl/irq_power_pkg.sv
// package: constants, types and field layouts for the interrupt, sleep and reset controller
package irq_power_pkg;
   // ---------------------------------------------------------------
   // bus map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_POWER = 8'h00; // power_control_reg
   localparam logic [7:0] ADDR_ENABLE = 8'h04; // irq_enable_reg
   localparam logic [7:0] ADDR_LEVEL = 8'h08; // irq_level_reg
   localparam logic [7:0] ADDR_TIMER_CTL = 8'h0C; // timer_control_reg
   localparam logic [7:0] ADDR_SERIAL_CTL = 8'h10; // serial_control_reg
   localparam logic [7:0] ADDR_TIMER2_CTL = 8'h14; // timer_two_control_reg
   localparam logic [7:0] ADDR_STATUS = 8'h18; // state and active level, read only
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int IDLE_BIT = 0;
   localparam int POWER_DOWN_BIT = 1;
   localparam int GLOBAL_EN_BIT = 7;
   localparam int EXT0_FLAG_BIT = 1;
   localparam int EXT0_TYPE_BIT = 0;
   localparam int EXT1_FLAG_BIT = 3;
   localparam int EXT1_TYPE_BIT = 2;
   localparam int T0_FLAG_BIT = 5;
   localparam int T1_FLAG_BIT = 7;
   localparam int RX_BIT = 0;
   localparam int TX_BIT = 1;
   localparam int T2_FLAG_BIT = 7;
   // ---------------------------------------------------------------
   // reset values and misc
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] LEVEL_READ_ONE = 8'h80; // level reg bit 7 reads as one
   localparam logic [7:0] PORT_RESET = 8'hFF;
   localparam logic [7:0] STACK_RESET = 8'h07;
   localparam int NUM_SRC = 6;
   localparam int RST_MIN_CYCLES = 4;
   localparam int STROBE_HOLD_CYCLES = 205;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // vectors in natural priority order
   localparam logic [7:0] VEC_EXT0 = 8'h03;
   localparam logic [7:0] VEC_T0 = 8'h0B;
   localparam logic [7:0] VEC_EXT1 = 8'h13;
   localparam logic [7:0] VEC_T1 = 8'h1B;
   localparam logic [7:0] VEC_SERIAL = 8'h23;
   localparam logic [7:0] VEC_T2 = 8'h2B;

   typedef enum logic [1:0] {
      RUN = 2'b00,
      IDLE = 2'b01,
      POWER_DOWN = 2'b10
   } power_state_t;

   // request from controller to core
   typedef struct packed {
      logic valid;
      logic [7:0] vector;
      logic [2:0] source;
   } vector_req_t;

   // peripheral event inputs (one-cycle set pulses)
   typedef struct packed {
      logic t0Ovf;
      logic t1Ovf;
      logic t2Ovf;
      logic txDone;
      logic rxDone;
   } periph_events_t;
endpackage

// >>> hdl/irq_power_reset_control.sv
// interrupt control, idle, power-down and reset sequencing with an AXI4-Lite register port
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Overview of operation
// - idle bit halts core, peripherals keep running
// - enabled interrupt in idle clears idle bit
// - after return, resume after idle-setting instruction
// - external reset also ends idle
// - power-down bit stops clock, state retained
// - only reset exits power-down; RAM kept
// - reset recognised after four sampled high cycles
// - strobes high in reset, 205 cycles after
// - registers clear; ports FFH, stack 07H
// - vector to fixed address, return resumes
// - low preempted by high only; high never
// - finish instruction; one more after return/write
// - global enable masks all, else per-source enables
// - assigned level beats natural priority
// - same level resolved by natural priority
// - fixed vectors 03,0B,13,1B,23,2B
// - timer flags clear on vectoring
// - type bit: falling edge or low level
// ---------------------------------------------------------------
module irq_power_reset_control
   import irq_power_pkg::*;
#(
   parameter int STROBE_HOLD = STROBE_HOLD_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic resetPin, // active-high external reset pin, asynchronous
   input wire logic ext_irq_zero_n, // external pin, active low
   input wire logic ext_irq_one_n, // external pin, active low
   input wire periph_events_t events, // same-clock peripheral set pulses
   input wire logic instrDone, // core finished an instruction
   input wire logic instrIsReturn, // finished instruction was return_from_interrupt
   input wire logic vectorAck, // core took the offered vector
   output vector_req_t vectorReq, // vector offered to core
   output logic coreHalt, // core frozen (idle or power-down)
   output logic clockStop, // oscillator gate for power-down
   output logic coreReset, // internal reset to core and registers
   output logic strobeHigh, // strobes and ports forced high
   output logic [7:0] portReset, // port latch reset value
   output logic [7:0] stackReset, // stack pointer reset value
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] rstSync; // reset pin sync pair
   logic [1:0] ext0Sync; // ext0 pin sync pair
   logic [1:0] ext1Sync; // ext1 pin sync pair
   logic ext0Prev; // previous synced level, for edge detect
   logic ext1Prev;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'b00;
         ext0Sync <= 2'b11;
         ext1Sync <= 2'b11;
         ext0Prev <= 1'b1;
         ext1Prev <= 1'b1;
      end else begin
         rstSync <= {rstSync[0], resetPin};
         ext0Sync <= {ext0Sync[0], ext_irq_zero_n};
         ext1Sync <= {ext1Sync[0], ext_irq_one_n};
         ext0Prev <= ext0Sync[1];
         ext1Prev <= ext1Sync[1];
      end
   end

   // ---------------------------------------------------------------
   // reset recognition and strobe hold
   // ---------------------------------------------------------------
   logic [2:0] rstCount; // consecutive high samples
   logic [8:0] holdCount; // cycles left with strobes held
   logic next_coreReset;
   assign next_coreReset = (rstCount == 3'(RST_MIN_CYCLES - 1)) && rstSync[1];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstCount <= 3'd0;
         coreReset <= 1'b1;
      end else if (!rstSync[1]) begin
         rstCount <= 3'd0;
         coreReset <= 1'b0;
      end else if (next_coreReset) begin
         coreReset <= 1'b1;
      end else begin
         rstCount <= rstCount + 3'd1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         holdCount <= 9'(STROBE_HOLD);
      end else if (coreReset) begin
         holdCount <= 9'(STROBE_HOLD);
      end else if (holdCount != 9'd0) begin
         holdCount <= holdCount - 9'd1;
      end
   end
   assign strobeHigh = coreReset || (holdCount != 9'd0);
   assign portReset = PORT_RESET;
   assign stackReset = STACK_RESET;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] power_control_reg;
   logic [7:0] irq_enable_reg;
   logic [7:0] irq_level_reg;
   logic [7:0] timer_control_reg;
   logic [7:0] serial_control_reg;
   logic [7:0] timer_two_control_reg;
   power_state_t powerState;
   logic [1:0] activeLevels; // bit1 high-level in service, bit0 low-level
   logic extraWait; // one more instruction before vectoring
   logic wrFire; // register write this cycle
   logic [7:0] wrAddr;
   logic [7:0] wrData;
   logic [NUM_SRC-1:0] pending; // per-source request
   logic [NUM_SRC-1:0] levelOf; // per-source assigned level
   logic [NUM_SRC-1:0] enableOf; // per-source enable
   logic take; // vector taken by core
   logic [2:0] takeSrc;

   // source order = natural priority: ext0,t0,ext1,t1,serial,t2
   assign pending = {timer_two_control_reg[T2_FLAG_BIT],
      serial_control_reg[RX_BIT] | serial_control_reg[TX_BIT],
      timer_control_reg[T1_FLAG_BIT], timer_control_reg[EXT1_FLAG_BIT],
      timer_control_reg[T0_FLAG_BIT], timer_control_reg[EXT0_FLAG_BIT]};
   assign levelOf = irq_level_reg[NUM_SRC-1:0];
   assign enableOf = irq_enable_reg[NUM_SRC-1:0];
   assign take = vectorReq.valid && vectorAck;
   assign takeSrc = vectorReq.source;

   // edge/level capture for external pins
   logic ext0Set;
   logic ext1Set;
   assign ext0Set = timer_control_reg[EXT0_TYPE_BIT] ? (ext0Prev && !ext0Sync[1]) : !ext0Sync[1];
   assign ext1Set = timer_control_reg[EXT1_TYPE_BIT] ? (ext1Prev && !ext1Sync[1]) : !ext1Sync[1];

   // timer/control flags: hardware set wins over software or vector clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_control_reg <= REG_RESET;
         serial_control_reg <= REG_RESET;
         timer_two_control_reg <= REG_RESET;
      end else if (coreReset) begin
         timer_control_reg <= REG_RESET;
         serial_control_reg <= REG_RESET;
         timer_two_control_reg <= REG_RESET;
      end else if (!clockStop) begin
         if (wrFire && wrAddr == ADDR_TIMER_CTL) begin
            timer_control_reg <= wrData;
         end else if (take) begin
            if (takeSrc == 3'd0 && timer_control_reg[EXT0_TYPE_BIT]) timer_control_reg[EXT0_FLAG_BIT] <= 1'b0;
            if (takeSrc == 3'd1) timer_control_reg[T0_FLAG_BIT] <= 1'b0;
            if (takeSrc == 3'd2 && timer_control_reg[EXT1_TYPE_BIT]) timer_control_reg[EXT1_FLAG_BIT] <= 1'b0;
            if (takeSrc == 3'd3) timer_control_reg[T1_FLAG_BIT] <= 1'b0;
         end
         // level mode follows pin; edge mode set-only
         if (!timer_control_reg[EXT0_TYPE_BIT]) timer_control_reg[EXT0_FLAG_BIT] <= ext0Set;
         else if (ext0Set) timer_control_reg[EXT0_FLAG_BIT] <= 1'b1;
         if (!timer_control_reg[EXT1_TYPE_BIT]) timer_control_reg[EXT1_FLAG_BIT] <= ext1Set;
         else if (ext1Set) timer_control_reg[EXT1_FLAG_BIT] <= 1'b1;
         if (events.t0Ovf) timer_control_reg[T0_FLAG_BIT] <= 1'b1;
         if (events.t1Ovf) timer_control_reg[T1_FLAG_BIT] <= 1'b1;
         if (wrFire && wrAddr == ADDR_SERIAL_CTL) serial_control_reg <= wrData;
         if (events.rxDone) serial_control_reg[RX_BIT] <= 1'b1;
         if (events.txDone) serial_control_reg[TX_BIT] <= 1'b1;
         if (wrFire && wrAddr == ADDR_TIMER2_CTL) timer_two_control_reg <= wrData;
         else if (take && takeSrc == 3'd5) timer_two_control_reg[T2_FLAG_BIT] <= 1'b0;
         if (events.t2Ovf) timer_two_control_reg[T2_FLAG_BIT] <= 1'b1;
      end
   end

   // enable and level registers; a write to either delays vectoring
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_reg <= REG_RESET;
         irq_level_reg <= REG_RESET;
      end else if (coreReset) begin
         irq_enable_reg <= REG_RESET;
         irq_level_reg <= REG_RESET;
      end else if (wrFire && !clockStop) begin
         if (wrAddr == ADDR_ENABLE) irq_enable_reg <= wrData;
         else if (wrAddr == ADDR_LEVEL) irq_level_reg <= wrData;
      end
   end

   // ---------------------------------------------------------------
   // arbitration: level first, then natural order
   // ---------------------------------------------------------------
   logic [NUM_SRC-1:0] eligible;
   logic [NUM_SRC-1:0] highReq;
   logic [NUM_SRC-1:0] pickSet;
   logic found;
   logic [2:0] pick;
   logic pickHigh;
   assign eligible = irq_enable_reg[GLOBAL_EN_BIT] ? (pending & enableOf) : '0;
   assign highReq = eligible & levelOf;
   assign pickSet = (highReq != '0) ? highReq : eligible;
   always_comb begin
      found = 1'b0;
      pick = 3'd0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pickSet[i]) begin
            found = 1'b1;
            pick = 3'(i);
         end
      end
   end
   assign pickHigh = levelOf[pick];
   // nesting: none while high active, only high over low
   logic allowed;
   assign allowed = found && !activeLevels[1] && (pickHigh || !activeLevels[0]);

   function automatic logic [7:0] vecOf(input logic [2:0] s);
      case (s)
         3'd0: vecOf = VEC_EXT0;
         3'd1: vecOf = VEC_T0;
         3'd2: vecOf = VEC_EXT1;
         3'd3: vecOf = VEC_T1;
         3'd4: vecOf = VEC_SERIAL;
         default: vecOf = VEC_T2;
      endcase
   endfunction

   // offer held until acknowledged, reset or power-down; only at an instruction boundary or in idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vectorReq <= '0;
      end else if (coreReset || clockStop) begin
         vectorReq <= '0;
      end else if (take) begin
         vectorReq <= '0;
      end else if (!vectorReq.valid && allowed && !extraWait && (instrDone || powerState == IDLE)) begin
         vectorReq <= {1'b1, vecOf(pick), pick};
      end
   end

   // one extra instruction after return or enable/level write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         extraWait <= 1'b0;
      end else if (coreReset) begin
         extraWait <= 1'b0;
      end else if ((instrDone && instrIsReturn) || (wrFire && (wrAddr == ADDR_ENABLE || wrAddr == ADDR_LEVEL))) begin
         extraWait <= 1'b1;
      end else if (instrDone) begin
         extraWait <= 1'b0;
      end
   end

   // in-service levels; return pops the highest
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         activeLevels <= 2'b00;
      end else if (coreReset) begin
         activeLevels <= 2'b00;
      end else if (take) begin
         activeLevels[levelOf[takeSrc]] <= 1'b1;
      end else if (instrDone && instrIsReturn) begin
         if (activeLevels[1]) activeLevels[1] <= 1'b0;
         else activeLevels[0] <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // power control and sleep state
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_control_reg <= REG_RESET;
         powerState <= RUN;
      end else if (coreReset) begin
         power_control_reg <= REG_RESET;
         powerState <= RUN;
      end else begin
         case (powerState)
            RUN: begin
               if (wrFire && wrAddr == ADDR_POWER) power_control_reg <= wrData;
               // mode entered after the writing instruction completes
               if (instrDone && power_control_reg[POWER_DOWN_BIT]) powerState <= POWER_DOWN;
               else if (instrDone && power_control_reg[IDLE_BIT]) powerState <= IDLE;
            end
            IDLE: begin
               if (wrFire && wrAddr == ADDR_POWER) power_control_reg <= wrData;
               if (eligible != '0) begin
                  power_control_reg[IDLE_BIT] <= 1'b0;
                  powerState <= RUN; // core resumes its saved next PC after return
               end
            end
            POWER_DOWN: begin
               powerState <= POWER_DOWN; // nothing but reset leaves
            end
            default: powerState <= RUN;
         endcase
      end
   end
   assign coreHalt = (powerState != RUN);
   assign clockStop = (powerState == POWER_DOWN);

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic awHeld;
   logic wHeld;
   logic [7:0] awAddrQ;
   logic [7:0] wDataQ;
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign wrFire = awHeld && wHeld && !s_axi_bvalid;
   assign wrAddr = awAddrQ;
   assign wrData = wDataQ;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrQ <= 8'h00;
         wDataQ <= 8'h00;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddrQ <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wDataQ <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
         if (wrFire) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddrQ <= ADDR_TIMER2_CTL && awAddrQ[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         if (s_axi_araddr == ADDR_POWER) s_axi_rdata <= {24'h0, power_control_reg};
         else if (s_axi_araddr == ADDR_ENABLE) s_axi_rdata <= {24'h0, irq_enable_reg};
         else if (s_axi_araddr == ADDR_LEVEL) s_axi_rdata <= {24'h0, irq_level_reg | LEVEL_READ_ONE};
         else if (s_axi_araddr == ADDR_TIMER_CTL) s_axi_rdata <= {24'h0, timer_control_reg};
         else if (s_axi_araddr == ADDR_SERIAL_CTL) s_axi_rdata <= {24'h0, serial_control_reg};
         else if (s_axi_araddr == ADDR_TIMER2_CTL) s_axi_rdata <= {24'h0, timer_two_control_reg};
         else if (s_axi_araddr == ADDR_STATUS) s_axi_rdata <= {26'h0, activeLevels, 2'b00, powerState};
         else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // irq_power_reset_control
